/* src/tpss_top.sv */
// stepper pulse sequencer: pwm pair, table chain engine, interval timer
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tpss_top #(
  parameter logic [15:0] INTERVAL_RESET = tpss_pkg::INTERVAL_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [31:0]      bus_rdata,
  output logic             irq,
  output logic             phase_a_out,
  output logic             phase_a_bar_out,
  output logic             phase_b_out,
  output logic             phase_b_bar_out
);
  import tpss_pkg::*;

  tpss_mode_e  mode_reg, mode_next;
  logic [15:0] cnt_reg;
  logic [15:0] cmp_reg [0:NCMP-1];
  logic [15:0] tbl_mem [0:NTBL_WORDS-1];
  logic [3:0]  out_reg;
  logic        busy_reg;
  logic [2:0]  k_reg;
  logic [5:0]  idx_reg;
  logic [5:0]  xcnt_reg;
  logic [15:0] tmr_reg;
  logic [15:0] interval_reg;
  logic [8:0]  taddr_reg;
  tpss_evt_s   status_reg, en_reg, evt_set, status_next;
  logic        irq_reg;
  logic [31:0] rdata_reg;

  // mode decode
  wire is_rev   = mode_reg inside {R_ACC, R_CON, R_DEC, R_STP};
  wire is_acc   = mode_reg inside {F_ACC, R_ACC};
  wire is_dec   = mode_reg inside {F_DEC, R_DEC};
  wire is_con   = mode_reg inside {F_CON, R_CON};
  wire is_stp   = mode_reg inside {F_STP, R_STP};
  wire counting = is_acc | is_con | is_dec;
  wire timing   = is_con | is_stp;

  // period match, chain start and end
  wire period_match = counting && (cnt_reg == cmp_reg[0]);
  wire chain_go     = period_match && (is_acc || is_dec) && !busy_reg;
  wire chain_end    = busy_reg && (k_reg == CHAIN_LAST);
  wire chain_last   = chain_end && (xcnt_reg == XFER_LAST);
  // interval of zero wraps to a full 65536 cycles
  wire tmr_exp      = timing && (tmr_reg == interval_reg - 16'h0001);

  // chain source word for the current compare register
  // reverse table swap
  wire [2:0]  src_tbl  = tpss_src_tbl(k_reg, is_rev);
  wire [15:0] src_word = tbl_mem[tpss_tbl_addr(src_tbl, idx_reg)];

  // ramp entry, named so the reload branches stay short
  wire mode_chg  = mode_next != mode_reg;
  wire enter_acc = mode_chg && (mode_next inside {F_ACC, R_ACC});
  wire enter_dec = mode_chg && (mode_next inside {F_DEC, R_DEC});

  // bus decode
  wire wr_ctrl = bus_wr && (bus_addr == OFS_CTRL);
  wire wr_clr  = bus_wr && (bus_addr == OFS_INT_CLR);
  wire wr_en   = bus_wr && (bus_addr == OFS_INT_EN);
  wire wr_int  = bus_wr && (bus_addr == OFS_INTERVAL);
  wire wr_ta   = bus_wr && (bus_addr == OFS_TBL_ADDR);
  wire wr_td   = bus_wr && (bus_addr == OFS_TBL_DATA);
  wire start   = wr_ctrl && bus_wdata[0] && (mode_reg == M_IDLE);
  wire tbl_ok  = taddr_reg < 9'(NTBL_WORDS);

  // events; a set in the clear cycle survives
  assign evt_set = '{tmr_expired: tmr_exp,
                     dec_done:    chain_last && is_dec,
                     acc_done:    chain_last && is_acc,
                     xfer:        chain_end};
  assign status_next = (status_reg & ~(wr_clr ? bus_wdata[3:0] : 4'h0))
                     | evt_set;

  // read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
    (bus_addr == OFS_CTRL)     ? {28'h0, mode_reg} :
    (bus_addr == OFS_STATUS)   ? {28'h0, status_reg} :
    (bus_addr == OFS_INT_EN)   ? {28'h0, en_reg} :
    (bus_addr == OFS_MODE)     ? {16'h0, xcnt_reg, idx_reg, mode_reg} :
    (bus_addr == OFS_INTERVAL) ? {16'h0, interval_reg} :
    (bus_addr == OFS_TBL_ADDR) ? {23'h0, taddr_reg} : 32'h0;

  // next mode
  // mode transitions
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      M_IDLE: if (start) mode_next = F_ACC;
      F_ACC:  if (chain_last) mode_next = F_CON;
      R_ACC:  if (chain_last) mode_next = R_CON;
      F_CON:  if (tmr_exp) mode_next = F_DEC;
      R_CON:  if (tmr_exp) mode_next = R_DEC;
      F_DEC:  if (chain_last) mode_next = F_STP;
      R_DEC:  if (chain_last) mode_next = R_STP;
      F_STP:  if (tmr_exp) mode_next = R_ACC;
      R_STP:  if (tmr_exp) mode_next = F_ACC;
      default: mode_next = M_IDLE;
    endcase
  end

  // mode register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) mode_reg <= M_IDLE;
    else        mode_reg <= mode_next;
  end

  // shared counter, halted while stopped so the outputs freeze
  // clear on period match
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)            cnt_reg <= 16'h0000;
    else if (period_match) cnt_reg <= 16'h0000;
    else if (counting)     cnt_reg <= cnt_reg + 16'h0001;
  end

  // pwm pins: pair j uses compares 2j and 2j+1
  // set on rise, clear on fall
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= 4'h0;
    end else if (counting) begin
      for (int j = 0; j < 4; j++) begin
        if (cnt_reg == cmp_reg[2*j+1])  out_reg[j] <= 1'b0;
        else if (cnt_reg == cmp_reg[2*j]) out_reg[j] <= 1'b1;
      end
    end
  end

  // chain engine: one compare register per cycle, eight cycles
  // eight-register chain
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      k_reg    <= 3'h0;
    end else if (chain_go) begin
      busy_reg <= 1'b1;
      k_reg    <= 3'h0;
    end else if (busy_reg) begin
      busy_reg <= !chain_end;
      k_reg    <= k_reg + 3'h1;
    end
  end

  // compare registers, destination fixed by k
  // word to fixed destination
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCMP; i++) cmp_reg[i] <= 16'h0000;
    end else if (busy_reg) begin
      cmp_reg[k_reg] <= src_word;
    end
  end

  // table index and ramp count, reloaded on each ramp entry
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idx_reg  <= IDX_BOTTOM;
      xcnt_reg <= 6'h00;
    end else if (enter_acc) begin
      idx_reg  <= IDX_BOTTOM;
      xcnt_reg <= 6'h00;
    end else if (enter_dec) begin
      idx_reg  <= IDX_TOP;
      xcnt_reg <= 6'h00;
    end else if (chain_end) begin
      idx_reg  <= is_acc ? idx_reg + IDX_STEP : idx_reg - IDX_STEP;
      xcnt_reg <= xcnt_reg + IDX_STEP;
    end
  end

  // interval timer runs in constant and stop, cleared on expiry
  // stop period timing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)                tmr_reg <= 16'h0000;
    else if (!timing || tmr_exp) tmr_reg <= 16'h0000;
    else                       tmr_reg <= tmr_reg + 16'h0001;
  end

  // software registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      interval_reg <= INTERVAL_RESET;
      taddr_reg    <= 9'h000;
      en_reg       <= '0;
    end else begin
      if (wr_int) interval_reg <= bus_wdata[15:0];
      if (wr_en)  en_reg       <= bus_wdata[3:0];
      if (wr_ta)       taddr_reg <= bus_wdata[8:0];
      else if (wr_td)  taddr_reg <= taddr_reg + 9'h001;
    end
  end

  // table storage, data only, no reset needed
  always_ff @(posedge mclk) begin
    if (wr_td && tbl_ok) tbl_mem[taddr_reg] <= bus_wdata[15:0];
  end

  // status, interrupt and read data
  // per-transfer event
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
      rdata_reg  <= 32'h0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_reg & en_reg);
      rdata_reg  <= bus_rd ? rd_mux : 32'h0;
    end
  end

  assign bus_rdata       = rdata_reg;
  assign irq             = irq_reg;
  assign phase_a_out     = out_reg[0];
  assign phase_a_bar_out = out_reg[1];
  assign phase_b_out     = out_reg[2];
  assign phase_b_bar_out = out_reg[3];

  property p_sync_clear;
    @(posedge mclk) disable iff (!rst_b) period_match |=> cnt_reg == 16'h0;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("counter not cleared on period match");

  property p_pwm_rise;
    @(posedge mclk) disable iff (!rst_b)
      counting && cnt_reg == cmp_reg[0] && cnt_reg != cmp_reg[1]
      |=> phase_a_out;
  endproperty
  a_pwm_rise: assert property (p_pwm_rise)
    else $error("phase a did not rise on its compare");

  property p_chain_len;
    @(posedge mclk) disable iff (!rst_b)
      chain_go |=> busy_reg [*8] ##1 !busy_reg;
  endproperty
  a_chain_len: assert property (p_chain_len)
    else $error("chain not eight cycles long");

  property p_acc_step;
    @(posedge mclk) disable iff (!rst_b)
      chain_end && is_acc |=> idx_reg == $past(idx_reg) + IDX_STEP;
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("acceleration index did not step up");

  property p_dec_step;
    @(posedge mclk) disable iff (!rst_b)
      chain_end && is_dec && !chain_last
      |=> idx_reg == $past(idx_reg) - IDX_STEP;
  endproperty
  a_dec_step: assert property (p_dec_step)
    else $error("deceleration index did not step down");

  property p_rev_swap;
    @(posedge mclk) disable iff (!rst_b)
      busy_reg && is_rev && k_reg == 3'h4
      |-> src_word == tbl_mem[tpss_tbl_addr(3'h7, idx_reg)];
  endproperty
  a_rev_swap: assert property (p_rev_swap)
    else $error("reverse did not swap channel four tables");

  property p_xfer_irq;
    @(posedge mclk) disable iff (!rst_b)
      chain_end && en_reg.xfer
      |=> status_reg.xfer ##1 (irq || !$past(en_reg.xfer));
  endproperty
  a_xfer_irq: assert property (p_xfer_irq)
    else $error("transfer did not raise interrupt");

  // a clear in the event cycle must not swallow the event
  property p_set_wins;
    @(posedge mclk) disable iff (!rst_b)
      evt_set.xfer |=> status_reg.xfer;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("transfer event lost to a clear");

  property p_acc_hold;
    @(posedge mclk) disable iff (!rst_b)
      chain_last && is_acc |=> is_con && !busy_reg ##1 !busy_reg;
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("constant speed not entered after ramp");

  property p_stop_hold;
    @(posedge mclk) disable iff (!rst_b)
      is_stp && !tmr_exp |=> $stable(cnt_reg) && $stable(out_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("outputs moved while stopped");

  property p_stop_dir;
    @(posedge mclk) disable iff (!rst_b)
      mode_reg == F_STP && tmr_exp |=> mode_reg == R_ACC;
  endproperty
  a_stop_dir: assert property (p_stop_dir)
    else $error("forward stop did not lead to reverse");
endmodule // tpss_top
`default_nettype wire

/* src/tpss_pkg.sv */
// constants, types and helpers of the stepper pulse sequencer
// Notes on behaviour
// - both channels count together and clear on channel zero period match
// - pwm mode 1: pin rises on first compare of pair, falls on second
// - each period match in acceleration or deceleration runs one chain writing all eight compare registers
// - acceleration reads tables from bottom index up, one step per chain
// - deceleration reads tables from top index downward, one step per chain
// - reverse swaps channel four tables a with d and b with c
// - each ramp is 49 chains of 16-bit words into fixed compare registers
// - every completed transfer raises an interrupt event
// - after acceleration hold last compares, interval timer runs to expiry
// - interval expiry ends constant speed, reloads for deceleration
// - after deceleration halt the counter, pins hold their levels
// - stop period timed by interval timer, expiry starts next acceleration
// - cycle repeats forward, stop, reverse, stop without end
// - fall compares sit below next rise so phases never overlap; the reverse swap puts b fall above b-bar rise, so b and b-bar overlap
package tpss_pkg;
  localparam int         NCMP        = 8;
  localparam int         NTBL_WORDS  = 392;
  localparam logic [5:0] IDX_BOTTOM  = 6'h00;
  localparam logic [5:0] IDX_TOP     = 6'h30;
  localparam logic [5:0] XFER_LAST   = 6'h30;
  localparam logic [5:0] IDX_STEP    = 6'h01;
  localparam logic [8:0] TBL_LEN     = 9'h031;
  localparam logic [2:0] CHAIN_LAST  = 3'h7;
  localparam logic [15:0] INTERVAL_DEF = 16'hBDDD;
  // register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_INT_CLR  = 8'h08;
  localparam logic [7:0] OFS_INT_EN   = 8'h0C;
  localparam logic [7:0] OFS_MODE     = 8'h10;
  localparam logic [7:0] OFS_INTERVAL = 8'h14;
  localparam logic [7:0] OFS_TBL_ADDR = 8'h18;
  localparam logic [7:0] OFS_TBL_DATA = 8'h1C;
  // event bits of status, clear and enable registers
  typedef struct packed {
    logic tmr_expired;
    logic dec_done;
    logic acc_done;
    logic xfer;
  } tpss_evt_s;
  // gray along forward acc, con, dec, stop, reverse acc, con, dec, stop
  typedef enum logic [3:0] {
    F_ACC = 4'h0, F_CON = 4'h1, F_DEC = 4'h3, F_STP = 4'h2,
    R_ACC = 4'h6, R_CON = 4'h7, R_DEC = 4'h5, R_STP = 4'h4,
    M_IDLE = 4'h8
  } tpss_mode_e;
  // table feeding compare register k; reverse mirrors channel four
  function automatic logic [2:0] tpss_src_tbl(input logic [2:0] k,
                                             input logic rev);
    return (rev && k[2]) ? {1'b1, ~k[1:0]} : k;
  endfunction
  // flat storage index of a table word
  function automatic logic [8:0] tpss_tbl_addr(input logic [2:0] tbl,
                                              input logic [5:0] idx);
    return {6'h00, tbl} * TBL_LEN + {3'h0, idx};
  endfunction
endpackage

/* tb/tpss_driver_model.sv */
// motor driver stage model: follows coil drive, flags shoot-through on the a bridge only
`timescale 1ns/10ps
`default_nettype none
module tpss_driver_model (
  input  wire logic   mclk,
  input  wire logic   rst_b,
  input  wire logic   coil_a,
  input  wire logic   coil_a_bar,
  input  wire logic   coil_b,
  input  wire logic   coil_b_bar,
  output logic        shoot_thru,
  output logic [15:0] step_cnt
);
  logic [3:0] coil_reg;
  logic [3:0] coil_next;

  assign coil_next = {coil_a, coil_a_bar, coil_b, coil_b_bar};

  // bridge overlap watch
  // a and a-bar on together would short the bridge, so it is sticky
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      coil_reg   <= 4'h0;
      shoot_thru <= 1'b0;
      step_cnt   <= 16'h0000;
    end else begin
      coil_reg <= coil_next;
      if (coil_a && coil_a_bar)
        shoot_thru <= 1'b1;
      if (coil_reg != coil_next)
        step_cnt <= step_cnt + 16'h0001; // any excitation change
    end
  end
endmodule // tpss_driver_model
`default_nettype wire

/* tb/test_two_phase_stepper_pulse_sequencer.sv */
// self-checking bench of the stepper pulse sequencer
`timescale 1ns/10ps
`default_nettype none
module test_two_phase_stepper_pulse_sequencer;
  import tpss_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic        irq;
  logic        pa, pab, pb, pbb;
  logic        shoot_thru;
  logic [15:0] step_cnt;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #2 mclk = ~mclk;

  tpss_top uut (.mclk(mclk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .irq(irq), .phase_a_out(pa),
    .phase_a_bar_out(pab), .phase_b_out(pb), .phase_b_bar_out(pbb));

  tpss_driver_model drv (.mclk(mclk), .rst_b(rst_b), .coil_a(pa),
    .coil_a_bar(pab), .coil_b(pb), .coil_b_bar(pbb),
    .shoot_thru(shoot_thru), .step_cnt(step_cnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle bus strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // table words: period shrinks with index, edges fixed
  function automatic logic [15:0] tv(input int t, input int i);
    logic [15:0] e [8] = '{16'h0060, 16'h0018, 16'h001C, 16'h002C,
                           16'h0010, 16'h0020, 16'h0024, 16'h002C};
    return (t == 0) ? e[0] - 16'(i) : e[t];
  endfunction

  task automatic test_reset;
    logic [31:0] d;
    rd(OFS_STATUS, d);
    chk(d, 32'h0);
    rd(OFS_MODE, d);
    chk(d[3:0], 32'h8);
    rd(OFS_INTERVAL, d);
    chk(d, 32'h0000_BDDD);
    // read data stand for one cycle only
    @(posedge mclk);
    #1 chk(bus_rdata, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, d);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    for (int t = 0; t < NCMP; t++)
      for (int i = 0; i < 49; i++) begin
        if (t == 0 && i == 0) wr(OFS_TBL_ADDR, 32'h0);
        wr(OFS_TBL_DATA, {16'h0000, tv(t, i)});
      end
    // address stepped once per word, 392 words in all
    rd(OFS_TBL_ADDR, d);
    chk(d, 32'h0000_0188);
    wr(OFS_INTERVAL, 32'h0000_00C8);
    rd(OFS_INTERVAL, d);
    chk(d, 32'h0000_00C8);
    wr(OFS_INT_EN, 32'h5);
    rd(OFS_INT_EN, d);
    chk(d, 32'h5);
    $display("test_reset done");
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    // look after the edge so the level has settled
    #1;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(irq, 1'b1);
  endtask

  // clear, enable one event, wait for it, then check the mode
  task automatic wait_evt(input logic [3:0] ev, input tpss_mode_e m);
    logic [31:0] d;
    wr(OFS_INT_CLR, 32'hF);
    wr(OFS_INT_EN, {28'h0, ev});
    wait_irq(8000);
    rd(OFS_MODE, d);
    chk(d[3:0], {28'h0, m});
    wr(OFS_INT_EN, 32'h0);
  endtask

  task automatic test_accel;
    logic [31:0] d;
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_CTRL, 32'h1);
    wait_irq(200);
    rd(OFS_MODE, d);
    chk(d[3:0], 32'h0);
    chk(d[9:4], 32'h1);
    wr(OFS_INT_EN, 32'h0);
    repeat (3) @(posedge mclk);
    #1 chk(irq, 1'b0);
    $display("test_accel done");
  endtask

  // high cycles of each pin over one 49-cycle period
  task automatic meas(input int ea, input int eab, input int eb,
                      input int ebb);
    int ca = 0, cab = 0, cb = 0, cbb = 0;
    repeat (49) begin
      @(posedge mclk);
      #1 ca += pa;
      cab += pab;
      cb += pb;
      cbb += pbb;
    end
    chk(ca, ea);
    chk(cab, eab);
    chk(cb, eb);
    chk(cbb, ebb);
  endtask

  task automatic test_run(input logic rev);
    logic [31:0] d;
    logic [15:0] s;
    logic [3:0]  p;
    wait_evt(4'h2, rev ? R_CON : F_CON);
    if (rev) meas(25, 16, 41, 33);
    else meas(25, 16, 16, 8);
    wait_evt(4'h8, rev ? R_DEC : F_DEC);
    wait_evt(4'h4, rev ? R_STP : F_STP);
    rd(OFS_MODE, d);
    chk(d[9:4], 32'h3F);
    s = step_cnt;
    p = {pa, pab, pb, pbb};
    repeat (50) @(posedge mclk);
    #1 chk(step_cnt, s);
    chk({pa, pab, pb, pbb}, p);
    wait_evt(4'h8, rev ? F_ACC : R_ACC);
    $display("test_run done, reverse %0d", rev);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    test_reset;
    test_accel;
    test_run(1'b0);
    test_run(1'b1);
    chk(shoot_thru, 1'b0);
    give_verdict;
  end

  // watchdog: whole run needs about 16000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    give_verdict;
  end
endmodule // test_two_phase_stepper_pulse_sequencer
`default_nettype wire
